// *** fsi_pkg.sv ***
// shared constants for the four-source interrupt and reset control block
// assumes one instruction-cycle clock and nibble-wide control memory
package fsi_pkg;
  localparam int FSI_SRC_N = 4;
  localparam int FSI_ADDR_W = 10;
  localparam int FSI_PC_W = 12;
  localparam int FSI_SP_W = 10;
  // nibble addresses of the control bits and the pin-function register
  localparam logic [FSI_ADDR_W-1:0] FSI_EXT_NIB = 10'h000;
  localparam logic [FSI_ADDR_W-1:0] FSI_TMR_NIB = 10'h001;
  localparam logic [FSI_ADDR_W-1:0] FSI_SER_NIB = 10'h002;
  localparam logic [FSI_ADDR_W-1:0] FSI_PIN_NIB = 10'h004;
  // bit positions inside the control nibbles
  localparam logic [1:0] FSI_ALLOW_BIT = 2'h0;
  localparam logic [1:0] FSI_RELOAD_BIT = 2'h1;
  localparam logic [1:0] FSI_EXT_PEND_BIT = 2'h2;
  localparam logic [1:0] FSI_EXT_BLK_BIT = 2'h3;
  localparam logic [1:0] FSI_TA_PEND_BIT = 2'h0;
  localparam logic [1:0] FSI_TA_BLK_BIT = 2'h1;
  localparam logic [1:0] FSI_TB_PEND_BIT = 2'h2;
  localparam logic [1:0] FSI_TB_BLK_BIT = 2'h3;
  localparam logic [1:0] FSI_SER_PEND_BIT = 2'h0;
  localparam logic [1:0] FSI_SER_BLK_BIT = 2'h1;
  // pin-function bits
  localparam int FSI_PIN_W = 3;
  localparam int FSI_EXT_ROUTE_BIT = 2;
  localparam int FSI_SIN_ROUTE_BIT = 1;
  localparam int FSI_SOUT_ROUTE_BIT = 0;
  // values after reset
  localparam logic [FSI_PIN_W-1:0] FSI_PIN_RST = 3'h0;
  localparam logic FSI_PEND_RST = 1'b0;
  localparam logic FSI_BLK_RST = 1'b1;
  localparam logic FSI_ALLOW_RST = 1'b0;
  localparam logic [FSI_SP_W-1:0] FSI_SP_INIT = 10'h0ff;
  localparam logic [FSI_PC_W-1:0] FSI_RESET_VEC = 12'h000;
  localparam logic [FSI_PC_W-1:0] FSI_VEC_STEP = 12'h002;
  // least low time of the reset pin, in instruction cycles
  localparam int FSI_RST_HOLD_CYC = 2;
  localparam logic [1:0] FSI_RST_HOLD = 2'(FSI_RST_HOLD_CYC);
  // bit operations issued by the core
  typedef enum logic [1:0] {FSI_OP_NONE, FSI_OP_SET, FSI_OP_CLR, FSI_OP_TEST} fsi_op_t;
  // interrupt entry sequence
  typedef enum logic [1:0] {FSI_ST_IDLE, FSI_ST_FINISH, FSI_ST_PUSH, FSI_ST_VEC} fsi_state_t;
endpackage

// *** fsi_req_if.sv ***
// request bundle between the control logic and the priority encoder
// assumes both ends share one clock; the bundle is purely combinational
`timescale 1ns/1ps
interface fsi_req_if;
  logic [fsi_pkg::FSI_SRC_N-1:0] req;
  logic any;
  logic [1:0] idx;
  logic [fsi_pkg::FSI_PC_W-1:0] vec;
  modport ctrl (output req, input any, input idx, input vec);
  modport enc (input req, output any, output idx, output vec);
endinterface

// *** fsi_src_flag.sv ***
// one interrupt source: its pending flag and its block (mask) bit
// assumes event and clear strobes are single-cycle, synchronous
`timescale 1ns/1ps
module fsi_src_flag
  import fsi_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic dev_rst_in,
  input wire logic event_in,
  input wire logic clr_pend_in,
  input wire logic set_blk_in,
  input wire logic clr_blk_in,
  output logic pending_out,
  output logic block_out
);
  logic pend_nxt;
  logic blk_nxt;
  // hardware event wins over a clear in the same cycle; no software set path
  assign pend_nxt = dev_rst_in ? FSI_PEND_RST :
                    event_in ? 1'b1 : (clr_pend_in ? 1'b0 : pending_out);
  assign blk_nxt = dev_rst_in ? FSI_BLK_RST :
                   set_blk_in ? 1'b1 : (clr_blk_in ? 1'b0 : block_out);
  // flag and mask storage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pending_out <= FSI_PEND_RST;
      block_out <= FSI_BLK_RST;
    end else begin
      pending_out <= pend_nxt;
      block_out <= blk_nxt;
    end
  end
endmodule

// *** fsi_prio_enc.sv ***
// fixed-priority selection of the unmasked requests and vector forming
// assumes request bit 0 is the highest priority source
`timescale 1ns/1ps
module fsi_prio_enc
  import fsi_pkg::*;
(
  fsi_req_if.enc req_if
);
  // lowest set bit wins; vector is two words per priority step
  always_comb begin
    req_if.idx = 2'h0;
    for (int i = FSI_SRC_N - 1; i >= 0; i--) begin
      if (req_if.req[i]) begin
        req_if.idx = 2'(i);
      end
    end
  end
  assign req_if.any = |req_if.req;
  assign req_if.vec = FSI_RESET_VEC + FSI_VEC_STEP * (12'(req_if.idx) + 12'h001);
endmodule

// *** fsi_irq_ctrl.sv ***
// interrupt control and reset handling of a 4-bit controller core
// assumes all inputs synchronous to the instruction-cycle clock
//
// Operation
// - stack pointer reload on reset or bit clear
// - reset pin low two cycles resets device
// - stop-exit reset keeps RAM; else contents undefined
// - four sources, each pending, mask, vector
// - control bits at nibbles 0 to 2
// - software can only clear pending flags
// - reset clears allow and pending, sets masks
// - request is pending and unmasked; allow gates
// - three-cycle entry: finish, clear and push, vector
// - vectors 2,4,6,8 by priority order
// - allow bit 0; entry clears, return sets
// - external pending on falling edge; mask bit 3
// - external input as timer clock needs mask
// - timer A pending bit 0, mask bit 1
// - timer B pending bit 2, mask bit 3
// - serial pending on eight clocks or abort
// - pin-function register write-only, reset zero
// - pin-function bits route the shared pins
// - bit set spares pending; some tests invalid
// - pushed flags restored only by return
`timescale 1ns/1ps
module fsi_irq_ctrl
  import fsi_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  // reset pin and low-power state
  input wire logic reset_pin_n_in,
  input wire logic stop_mode_in,
  // bit and nibble access from the core
  input wire fsi_pkg::fsi_op_t bit_op_in,
  input wire logic [fsi_pkg::FSI_ADDR_W-1:0] bit_addr_in,
  input wire logic [1:0] bit_sel_in,
  input wire logic nib_wr_in,
  input wire logic [3:0] nib_wdata_in,
  // instruction flow from the core
  input wire logic instr_done_in,
  input wire logic return_from_irq_in,
  input wire logic [fsi_pkg::FSI_PC_W-1:0] program_counter_in,
  input wire logic arith_overflow_bit_in,
  input wire logic branch_cond_flag_in,
  // event sources
  input wire logic ext_pin_n_in,
  input wire logic tmr_a_ovf_in,
  input wire logic tmr_b_ovf_in,
  input wire logic serial_done_in,
  input wire logic serial_abort_in,
  // answers to the core
  output logic test_result_out,
  output logic test_invalid_out,
  output logic [3:0] nib_rdata_out,
  output logic dev_reset_out,
  output logic ram_keep_out,
  output logic regs_undef_out,
  output logic sp_load_out,
  output logic [fsi_pkg::FSI_SP_W-1:0] sp_value_out,
  output logic irq_take_out,
  output logic push_out,
  output logic [fsi_pkg::FSI_PC_W-1:0] push_pc_out,
  output logic push_carry_out,
  output logic push_cond_out,
  output logic restore_flags_out,
  output logic vector_valid_out,
  output logic [fsi_pkg::FSI_PC_W-1:0] vector_out,
  output logic global_irq_allow_out,
  output logic [fsi_pkg::FSI_SRC_N-1:0] pending_out,
  output logic [fsi_pkg::FSI_SRC_N-1:0] block_out,
  // shared pin routing
  output logic ext_pin_route_bit_out,
  output logic serial_in_route_bit_out,
  output logic serial_out_route_bit_out,
  output logic tmr_b_ext_clk_out
);
  import fsi_pkg::*;

  // reset pin qualification
  logic [1:0] rst_cnt_r;
  logic [1:0] rst_cnt_nxt;
  logic dev_rst;
  logic stop_seen_r;
  // control storage
  logic allow_r;
  logic allow_nxt;
  logic [FSI_PIN_W-1:0] pin_sel_r;
  logic [FSI_PIN_W-1:0] pin_sel_nxt;
  logic ext_prev_r;
  // entry sequence
  fsi_state_t state_r;
  fsi_state_t state_nxt;
  logic [1:0] win_idx_r;
  // decode
  logic hit_ext;
  logic hit_tmr;
  logic hit_ser;
  logic hit_pin;
  logic op_set;
  logic op_clr;
  logic op_test;
  logic [3:0] sel_mask;
  logic [3:0] ext_nib;
  logic [3:0] tmr_nib;
  logic [3:0] ser_nib;
  logic [3:0] cur_nib;
  logic [FSI_SRC_N-1:0] src_event;
  logic [FSI_SRC_N-1:0] clr_pend;
  logic [FSI_SRC_N-1:0] set_blk;
  logic [FSI_SRC_N-1:0] clr_blk;
  logic ext_fall;
  logic reload_clr;
  logic entry_clear;
  logic bad_test;

  fsi_req_if req_if ();

  // reset pin low for the hold count asserts the device reset
  assign rst_cnt_nxt = reset_pin_n_in ? 2'h0 :
                       (rst_cnt_r == FSI_RST_HOLD) ? rst_cnt_r : rst_cnt_r + 2'h1;
  assign dev_rst = (rst_cnt_r == FSI_RST_HOLD);

  // low-time counter and stop-mode memory
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_cnt_r <= 2'h0;
      stop_seen_r <= 1'b0;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
      stop_seen_r <= dev_rst ? stop_seen_r : stop_mode_in;
    end
  end

  // reset outcome seen by the core and its memories
  assign dev_reset_out = dev_rst;
  assign ram_keep_out = dev_rst & stop_seen_r;
  assign regs_undef_out = dev_rst;

  // address and operation decode
  assign hit_ext = (bit_addr_in == FSI_EXT_NIB);
  assign hit_tmr = (bit_addr_in == FSI_TMR_NIB);
  assign hit_ser = (bit_addr_in == FSI_SER_NIB);
  assign hit_pin = (bit_addr_in == FSI_PIN_NIB);
  assign op_set = (bit_op_in == FSI_OP_SET);
  assign op_clr = (bit_op_in == FSI_OP_CLR);
  assign op_test = (bit_op_in == FSI_OP_TEST);
  assign sel_mask = 4'h1 << bit_sel_in;

  // current nibble images; unused bits read zero
  assign ext_nib = {block_out[0], pending_out[0], 1'b0, allow_r};
  assign tmr_nib = {block_out[2], pending_out[2], block_out[1], pending_out[1]};
  assign ser_nib = {2'h0, block_out[3], pending_out[3]};
  assign cur_nib = hit_ext ? ext_nib : hit_tmr ? tmr_nib : hit_ser ? ser_nib : 4'h0;

  // events: external falling edge only while the pin is routed
  assign ext_fall = ext_prev_r & ~ext_pin_n_in & pin_sel_r[FSI_EXT_ROUTE_BIT];
  assign src_event[0] = ext_fall;
  assign src_event[1] = tmr_a_ovf_in;
  assign src_event[2] = tmr_b_ovf_in;
  assign src_event[3] = serial_done_in | serial_abort_in;

  // pending clears come only from the bit clear; set never reaches them
  assign clr_pend[0] = op_clr & hit_ext & (bit_sel_in == FSI_EXT_PEND_BIT);
  assign clr_pend[1] = op_clr & hit_tmr & (bit_sel_in == FSI_TA_PEND_BIT);
  assign clr_pend[2] = op_clr & hit_tmr & (bit_sel_in == FSI_TB_PEND_BIT);
  assign clr_pend[3] = op_clr & hit_ser & (bit_sel_in == FSI_SER_PEND_BIT);

  // mask set and clear strobes
  assign set_blk[0] = op_set & hit_ext & (bit_sel_in == FSI_EXT_BLK_BIT);
  assign set_blk[1] = op_set & hit_tmr & (bit_sel_in == FSI_TA_BLK_BIT);
  assign set_blk[2] = op_set & hit_tmr & (bit_sel_in == FSI_TB_BLK_BIT);
  assign set_blk[3] = op_set & hit_ser & (bit_sel_in == FSI_SER_BLK_BIT);
  assign clr_blk[0] = op_clr & hit_ext & (bit_sel_in == FSI_EXT_BLK_BIT);
  assign clr_blk[1] = op_clr & hit_tmr & (bit_sel_in == FSI_TA_BLK_BIT);
  assign clr_blk[2] = op_clr & hit_tmr & (bit_sel_in == FSI_TB_BLK_BIT);
  assign clr_blk[3] = op_clr & hit_ser & (bit_sel_in == FSI_SER_BLK_BIT);

  // one flag pair per source
  for (genvar g = 0; g < FSI_SRC_N; g++) begin : g_src
    fsi_src_flag u_flag (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .dev_rst_in(dev_rst),
      .event_in(src_event[g]),
      .clr_pend_in(clr_pend[g]),
      .set_blk_in(set_blk[g]),
      .clr_blk_in(clr_blk[g]),
      .pending_out(pending_out[g]),
      .block_out(block_out[g])
    );
  end

  // request per source: pending and not blocked
  assign req_if.req = pending_out & ~block_out;

  fsi_prio_enc u_enc (
    .req_if(req_if)
  );

  // bit tests: unused bits, the reload bit and the write-only nibble are invalid
  assign bad_test = (hit_ext & (bit_sel_in == FSI_RELOAD_BIT)) |
                    (hit_ser & bit_sel_in[1]) | hit_pin;
  assign test_invalid_out = op_test & bad_test;
  assign test_result_out = op_test & ~bad_test & |(cur_nib & sel_mask);
  assign nib_rdata_out = cur_nib;

  // stack pointer reload on reset or on clearing the reload bit
  assign reload_clr = op_clr & hit_ext & (bit_sel_in == FSI_RELOAD_BIT);
  assign sp_load_out = dev_rst | reload_clr;
  assign sp_value_out = FSI_SP_INIT;

  // global allow: entry clears it, return or a bit set raises it
  assign entry_clear = (state_r == FSI_ST_PUSH);
  assign allow_nxt = dev_rst ? FSI_ALLOW_RST :
                     entry_clear ? 1'b0 :
                     return_from_irq_in ? 1'b1 :
                     (op_set & hit_ext & (bit_sel_in == FSI_ALLOW_BIT)) ? 1'b1 :
                     (op_clr & hit_ext & (bit_sel_in == FSI_ALLOW_BIT)) ? 1'b0 : allow_r;

  // pin-function register; bit 3 of the write data is dropped
  assign pin_sel_nxt = dev_rst ? FSI_PIN_RST :
                       (nib_wr_in & hit_pin) ? nib_wdata_in[FSI_PIN_W-1:0] : pin_sel_r;

  // allow, pin routing and edge history
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      allow_r <= FSI_ALLOW_RST;
      pin_sel_r <= FSI_PIN_RST;
      ext_prev_r <= 1'b1;
    end else begin
      allow_r <= allow_nxt;
      pin_sel_r <= pin_sel_nxt;
      ext_prev_r <= ext_pin_n_in;
    end
  end

  assign global_irq_allow_out = allow_r;
  assign ext_pin_route_bit_out = pin_sel_r[FSI_EXT_ROUTE_BIT];
  assign serial_in_route_bit_out = pin_sel_r[FSI_SIN_ROUTE_BIT];
  assign serial_out_route_bit_out = pin_sel_r[FSI_SOUT_ROUTE_BIT];
  // timer B may count the external falling edges; masking is software's job
  assign tmr_b_ext_clk_out = ext_fall;

  // entry sequence: held request waits for allow, then finish until instr_done_in, push, vector
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FSI_ST_IDLE: begin
        if (allow_r & req_if.any) begin
          state_nxt = FSI_ST_FINISH;
        end
      end
      FSI_ST_FINISH: begin
        if (instr_done_in) begin
          state_nxt = FSI_ST_PUSH;
        end
      end
      FSI_ST_PUSH: begin
        state_nxt = FSI_ST_VEC;
      end
      FSI_ST_VEC: begin
        state_nxt = FSI_ST_IDLE;
      end
    endcase
  end

  // state and winning source capture
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= FSI_ST_IDLE;
      win_idx_r <= 2'h0;
    end else begin
      state_r <= dev_rst ? FSI_ST_IDLE : state_nxt;
      win_idx_r <= (state_r == FSI_ST_FINISH) ? req_if.idx : win_idx_r;
    end
  end

  // push data captured as the sequence moves into its second cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      push_pc_out <= FSI_RESET_VEC;
      push_carry_out <= 1'b0;
      push_cond_out <= 1'b1;
      vector_out <= FSI_RESET_VEC;
    end else begin
      if ((state_r == FSI_ST_FINISH) & instr_done_in) begin
        push_pc_out <= program_counter_in;
        push_carry_out <= arith_overflow_bit_in;
        push_cond_out <= branch_cond_flag_in;
      end
      if (state_r == FSI_ST_PUSH) begin
        vector_out <= FSI_VEC_STEP * (12'(win_idx_r) + 12'h001);
      end
    end
  end

  // sequence strobes to the core
  assign irq_take_out = entry_clear;
  assign push_out = (state_r == FSI_ST_PUSH) | (state_r == FSI_ST_VEC);
  assign vector_valid_out = (state_r == FSI_ST_VEC);
  // pushed carry and branch flag come back only on return
  assign restore_flags_out = return_from_irq_in;
endmodule

// *** fsi_core_model.sv ***
// core-side model: retires instructions and offers values to push
// assumes it shares the instruction-cycle clock with the control block
`timescale 1ns/1ps
module fsi_core_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  output logic instr_done_out,
  output logic [fsi_pkg::FSI_PC_W-1:0] pc_out,
  output logic carry_out,
  output logic cond_out
);
  logic [1:0] cnt_r;
  // program counter advances on each retired instruction
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 2'h0;
      pc_out <= 12'h000;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      if (instr_done_out) begin
        pc_out <= pc_out + 12'h001;
      end
    end
  end
  // slow mode: long instructions, one retire every four cycles
  assign instr_done_out = !slow_in || (cnt_r == 2'h3);
  assign carry_out = pc_out[0];
  assign cond_out = !pc_out[0];
endmodule

// *** fsi_irq_ctrl_properties.sv ***
// assertions on the interrupt and reset control ports
// assumes one clock domain; attached by the bind at the foot
`timescale 1ns/1ps
module fsi_irq_ctrl_properties
  import fsi_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire fsi_pkg::fsi_op_t bit_op_in,
  input wire logic [fsi_pkg::FSI_ADDR_W-1:0] bit_addr_in,
  input wire logic [1:0] bit_sel_in,
  input wire logic nib_wr_in,
  input wire logic [3:0] nib_wdata_in,
  input wire logic ext_pin_n_in,
  input wire logic tmr_a_ovf_in,
  input wire logic test_invalid_out,
  input wire logic dev_reset_out,
  input wire logic ram_keep_out,
  input wire logic sp_load_out,
  input wire logic irq_take_out,
  input wire logic vector_valid_out,
  input wire logic [fsi_pkg::FSI_PC_W-1:0] vector_out,
  input wire logic global_irq_allow_out,
  input wire logic [fsi_pkg::FSI_SRC_N-1:0] pending_out,
  input wire logic [fsi_pkg::FSI_SRC_N-1:0] block_out,
  input wire logic ext_pin_route_bit_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // decoded reload-bit accesses and winning source index
  wire logic on_reload = bit_addr_in == FSI_EXT_NIB && bit_sel_in == FSI_RELOAD_BIT;
  wire logic reload_clr = on_reload && bit_op_in == FSI_OP_CLR;
  wire logic reload_test = on_reload && bit_op_in == FSI_OP_TEST;
  wire logic [2:0] win = vector_out[3:1] - 3'h1;
  a_stack_reload: assert property (reload_clr || dev_reset_out |-> sp_load_out)
    else $error("stack reload not requested");
  a_reset_hold: assert property ((!reset_pin_n_in) [*2] |=> dev_reset_out)
    else $error("reset pin low two cycles ignored");
  a_reset_short: assert property ($rose(dev_reset_out) |-> $past(reset_pin_n_in, 2) == 1'b0)
    else $error("device reset after short pulse");
  a_ram_keep: assert property (ram_keep_out |-> dev_reset_out)
    else $error("ram keep outside reset");
  a_reset_values: assert property (dev_reset_out |=> pending_out == 4'h0 && block_out == 4'hf
    && !global_irq_allow_out && !ext_pin_route_bit_out)
    else $error("reset values wrong");
  a_event_only: assert property ($rose(pending_out[1]) |-> $past(tmr_a_ovf_in))
    else $error("pending set without event");
  a_ext_edge: assert property ($fell(ext_pin_n_in) && ext_pin_route_bit_out && !dev_reset_out
    |=> pending_out[0])
    else $error("external edge lost");
  a_take_cause: assert property (irq_take_out |-> global_irq_allow_out
    && (pending_out & ~block_out) != 4'h0)
    else $error("entry without cause");
  a_entry_order: assert property (irq_take_out |=> vector_valid_out ##1 !global_irq_allow_out)
    else $error("entry sequence broken");
  a_vec_prio: assert property (vector_valid_out |-> pending_out[win]
    && vector_out inside {12'h002, 12'h004, 12'h006, 12'h008})
    else $error("vector not of a pending source");
  a_route_write: assert property (nib_wr_in && bit_addr_in == FSI_PIN_NIB && !dev_reset_out
    |=> {1'b0, ext_pin_route_bit_out, 2'h0} == ($past(nib_wdata_in) & 4'h4))
    else $error("route bit not stored");
  a_bad_test: assert property (reload_test |-> test_invalid_out)
    else $error("reload test not invalid");
  c_take: cover property (irq_take_out);
  c_keep: cover property (ram_keep_out);
  c_last: cover property (vector_valid_out && vector_out == 12'h008);
endmodule
bind fsi_irq_ctrl fsi_irq_ctrl_properties u_props (.clk_in(clk_in), .rst_in(rst_in),
  .reset_pin_n_in(reset_pin_n_in), .bit_op_in(bit_op_in), .bit_addr_in(bit_addr_in),
  .bit_sel_in(bit_sel_in), .nib_wr_in(nib_wr_in), .nib_wdata_in(nib_wdata_in),
  .ext_pin_n_in(ext_pin_n_in), .tmr_a_ovf_in(tmr_a_ovf_in), .test_invalid_out(test_invalid_out),
  .dev_reset_out(dev_reset_out), .ram_keep_out(ram_keep_out), .sp_load_out(sp_load_out),
  .irq_take_out(irq_take_out), .vector_valid_out(vector_valid_out), .vector_out(vector_out),
  .global_irq_allow_out(global_irq_allow_out), .pending_out(pending_out),
  .block_out(block_out), .ext_pin_route_bit_out(ext_pin_route_bit_out));

// *** tb.sv ***
// self-checking bench for the interrupt and reset control block
// assumes the core model and the bound checker compile alongside
`timescale 1ns/1ps
module tb;
  import fsi_pkg::*;
  localparam logic [11:0] IMG = 12'h2a8;
  logic clk = 1'b0, rst = 1'b1, rpin = 1'b1, stop = 1'b0, nwr = 1'b0, rti = 1'b0;
  logic slow = 1'b0, extn = 1'b1, ta = 1'b0, tbo = 1'b0, sdone = 1'b0, sabt = 1'b0;
  fsi_op_t op = FSI_OP_NONE;
  logic [9:0] addr = 10'h000;
  logic [1:0] sel = 2'h0;
  logic [3:0] nwd = 4'h0;
  logic done, ca, st, tres, tinv, dres, keep, spl, take, vv, allow, rext, rsin, rsout;
  logic [11:0] pc, vec;
  logic [3:0] rdat, pend, blk;
  logic psh, pca, pst, rund, rfl, tbclk;
  logic [11:0] ppc;
  logic [9:0] sval;
  int bad_count = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  fsi_core_model core (.clk_in(clk), .rst_in(rst), .slow_in(slow), .instr_done_out(done),
    .pc_out(pc), .carry_out(ca), .cond_out(st));
  fsi_irq_ctrl dut (.clk_in(clk), .rst_in(rst), .reset_pin_n_in(rpin), .stop_mode_in(stop),
    .bit_op_in(op), .bit_addr_in(addr), .bit_sel_in(sel), .nib_wr_in(nwr), .nib_wdata_in(nwd),
    .instr_done_in(done), .return_from_irq_in(rti), .program_counter_in(pc),
    .arith_overflow_bit_in(ca), .branch_cond_flag_in(st), .ext_pin_n_in(extn),
    .tmr_a_ovf_in(ta), .tmr_b_ovf_in(tbo), .serial_done_in(sdone), .serial_abort_in(sabt),
    .test_result_out(tres), .test_invalid_out(tinv), .nib_rdata_out(rdat),
    .dev_reset_out(dres), .ram_keep_out(keep), .regs_undef_out(rund), .sp_load_out(spl),
    .sp_value_out(sval), .irq_take_out(take), .push_out(psh), .push_pc_out(ppc),
    .push_carry_out(pca), .push_cond_out(pst), .restore_flags_out(rfl),
    .vector_valid_out(vv), .vector_out(vec),
    .global_irq_allow_out(allow), .pending_out(pend), .block_out(blk),
    .ext_pin_route_bit_out(rext), .serial_in_route_bit_out(rsin),
    .serial_out_route_bit_out(rsout), .tmr_b_ext_clk_out(tbclk));
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %0t %s: %h not %h", $time, msg, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // hold one core operation a cycle; returns reload, invalid, result
  task automatic probe(input fsi_op_t o, input logic [9:0] a, input logic [1:0] s,
      output logic [2:0] r);
    @(posedge clk);
    op <= o;
    addr <= a;
    sel <= s;
    #1;
    r = {spl, tinv, tres};
    @(posedge clk);
    op <= FSI_OP_NONE;
  endtask
  // operation on the pending bit of source i, or its block bit with off 1
  task automatic pbit(input fsi_op_t o, input int i, input logic [1:0] off);
    logic [2:0] r;
    probe(o, 10'(i == 0 ? 0 : (i == 3 ? 2 : 1)), (i[0] ? 2'h0 : 2'h2) + off, r);
  endtask
  task automatic wr_pin(input logic [9:0] a, input logic [3:0] d);
    @(posedge clk);
    nwr <= 1'b1;
    addr <= a;
    nwd <= d;
    @(posedge clk);
    nwr <= 1'b0;
    #1;
  endtask
  task automatic wait_vec(output logic [11:0] v);
    int i;
    for (i = 0; i < 60; i++) begin
      cyc(1);
      if (vv === 1'b1) break;
    end
    if (i == 60) begin
      bad_count++;
      $display("unexpected %0t no vector", $time);
      conclude();
    end else begin
      v = vec;
    end
  endtask
  task automatic s_reset_vals();
    for (int a = 0; a < 3; a++) begin
      @(posedge clk);
      addr <= 10'(a);
      #1;
      chk(12'(rdat), 12'(IMG[a*4 +: 4]), "image");
    end
    chk({allow, pend, blk, rext, rsin, rsout}, 12'h078, "reset flags");
  endtask
  task automatic s_bit_ops();
    logic [2:0] r;
    probe(FSI_OP_CLR, FSI_EXT_NIB, FSI_RELOAD_BIT, r);
    chk(12'(r), 12'h4, "reload clear");
    probe(FSI_OP_TEST, FSI_EXT_NIB, FSI_RELOAD_BIT, r);
    chk(12'(r), 12'h2, "reload test");
    probe(FSI_OP_TEST, FSI_SER_NIB, 2'h3, r);
    chk(12'(r), 12'h2, "unused test");
    probe(FSI_OP_TEST, FSI_EXT_NIB, FSI_EXT_BLK_BIT, r);
    chk(12'(r), 12'h1, "mask test");
    for (int i = 0; i < 4; i++) begin
      pbit(FSI_OP_SET, i, 2'h0);
    end
    cyc(1);
    chk(12'(pend), 12'h0, "set pending");
  endtask
  task automatic s_pin();
    for (int v = 0; v < 8; v++) begin
      wr_pin(FSI_PIN_NIB, 4'(v));
      chk(12'({rext, rsin, rsout}), 12'(v), "route");
    end
    wr_pin(10'h003, 4'h0);
    chk(12'({rext, rsin, rsout}), 12'h7, "route other addr");
  endtask
  task automatic s_irq();
    logic [11:0] v;
    logic [2:0] r;
    @(posedge clk);
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      pbit(FSI_OP_CLR, i, 2'h1);
    end
    @(posedge clk);
    extn <= 1'b0;
    ta <= 1'b1;
    tbo <= 1'b1;
    sabt <= 1'b1;
    #1;
    chk(12'(tbclk), 12'h001, "timer b clock");
    @(posedge clk);
    extn <= 1'b1;
    ta <= 1'b0;
    tbo <= 1'b0;
    sabt <= 1'b0;
    cyc(4);
    chk(12'({take, pend}), 12'h0f, "held requests");
    probe(FSI_OP_SET, FSI_EXT_NIB, FSI_ALLOW_BIT, r);
    for (int i = 0; i < 4; i++) begin
      wait_vec(v);
      chk(v, 12'(2 * i + 2), "vector");
      chk(ppc, pc - 12'h001, "pushed pc");
      chk(12'({psh, pca, pst}), {9'h000, 1'b1, ppc[0], ~ppc[0]}, "push flags");
      cyc(1);
      chk(12'({allow, pend}), {8'h00, 4'(4'hf << i)}, "after entry");
      pbit(FSI_OP_CLR, i, 2'h0);
      @(posedge clk);
      rti <= 1'b1;
      #1;
      chk(12'(rfl), 12'h001, "restore flags");
      @(posedge clk);
      rti <= 1'b0;
    end
    @(posedge clk);
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    wait_vec(v);
    chk(v, 12'h008, "serial done");
    pbit(FSI_OP_CLR, 3, 2'h0);
  endtask
  task automatic s_dev();
    @(posedge clk);
    stop <= 1'b1;
    rpin <= 1'b0;
    @(posedge clk);
    rpin <= 1'b1;
    cyc(2);
    chk(12'(dres), 12'h0, "short reset");
    @(posedge clk);
    rpin <= 1'b0;
    cyc(2);
    chk(12'({dres, keep, spl}), 12'h7, "stop exit reset");
    chk(12'({rund, sval}), 12'({1'b1, FSI_SP_INIT}), "sp value");
    @(posedge clk);
    rpin <= 1'b1;
    stop <= 1'b0;
    cyc(1);
    chk({allow, pend, blk, rext, rsin, rsout}, 12'h078, "device reset");
    @(posedge clk);
    rpin <= 1'b0;
    cyc(2);
    chk(12'({dres, keep}), 12'h2, "plain reset");
    @(posedge clk);
    rpin <= 1'b1;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    s_reset_vals();
    s_bit_ops();
    s_pin();
    s_irq();
    s_dev();
    cyc(2);
    conclude();
  end
endmodule
